/* src/pmr_pkg.sv */
// Shared constants and types of the programmable macrocell block.
package pmr_pkg;
  localparam int unsigned PMR_NUM_MC = 16;
  localparam int unsigned PMR_NUM_IN = 36;
  localparam int unsigned PMR_NUM_PT = 5;
  // Five local terms plus the shareable expander term of each macrocell.
  localparam int unsigned PMR_PT_PER_MC = 6;
  localparam int unsigned PMR_WORDS_PER_PT = 4;
  localparam int unsigned PMR_AW = 12;
  localparam int unsigned PMR_TIW = 9;
  localparam int unsigned PMR_TEST_PINS = 4;
  localparam int unsigned PMR_CHAIN = 8;

  localparam logic [11:0] PMR_OFF_CTRL = 12'h000;
  localparam logic [11:0] PMR_OFF_GCLK = 12'h004;
  localparam logic [11:0] PMR_OFF_DED = 12'h008;
  localparam logic [11:0] PMR_OFF_STAT = 12'h00c;
  localparam logic [11:0] PMR_OFF_MC = 12'h100;
  localparam logic [11:0] PMR_OFF_TERM = 12'h800;

  localparam int unsigned PMR_CTRL_RELOAD = 0;
  localparam int unsigned PMR_CTRL_TEST = 1;
  localparam int unsigned PMR_STAT_INIT = 31;
  localparam int unsigned PMR_STAT_Q = 16;

  localparam int unsigned PMR_GCLK_SRC0 = 0;
  localparam int unsigned PMR_GCLK_INV0 = 1;
  localparam int unsigned PMR_GCLK_SRC1 = 2;
  localparam int unsigned PMR_GCLK_INV1 = 3;
  localparam logic [3:0] PMR_GCLK_RST = 4'h4;

  localparam int unsigned PMR_DED_CLKA = 0;
  localparam int unsigned PMR_DED_CLR = 1;
  localparam int unsigned PMR_DED_OEA = 2;
  localparam int unsigned PMR_DED_PINB_OE = 3;
  localparam logic [3:0] PMR_DED_RST = 4'h3;

  localparam int unsigned PMR_MC_SUM = 0;
  localparam int unsigned PMR_MC_FF = 5;
  localparam int unsigned PMR_MC_CKM = 7;
  localparam int unsigned PMR_MC_BYP = 9;
  localparam int unsigned PMR_MC_XINV = 10;
  localparam int unsigned PMR_MC_GCLR = 11;
  localparam int unsigned PMR_MC_PWRUP = 12;
  localparam int unsigned PMR_MC_PIN = 13;
  localparam int unsigned PMR_MC_HOLD = 14;
  localparam int unsigned PMR_MC_LEND = 15;
  localparam int unsigned PMR_MC_NET = 16;
  localparam int unsigned PMR_MC_W = 17;
  localparam logic [16:0] PMR_MC_RST = 17'h00000;

  localparam int unsigned PMR_PT_PRE = 1;
  localparam int unsigned PMR_PT_CLK = 2;
  localparam int unsigned PMR_PT_CLR = 3;
  localparam int unsigned PMR_PT_K = 4;

  typedef enum logic [1:0] {PMR_FF_D, PMR_FF_T, PMR_FF_JK, PMR_FF_SR} pmr_ff_type;
  typedef enum logic [1:0] {PMR_CK_GLOBAL, PMR_CK_GLOBAL_EN, PMR_CK_ARRAY} pmr_ckmode_type;
  typedef enum logic {PMR_ST_INIT, PMR_ST_RUN} pmr_state_type;
endpackage : pmr_pkg

/* src/pmr_gclk_net.sv */
// One global clock net: pin choice, optional inversion and edge detect.
`timescale 1ns/100ps
`default_nettype none
module pmr_gclk_net (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic src,
  input wire logic inv,
  output logic net_reg,
  output logic rise
);
  import pmr_pkg::*;
  logic net_next;

  assign net_next = (src ? pin_b : pin_a) ^ inv;
  // The rise is seen in the cycle the sampled pin level changes.
  assign rise = net_next & ~net_reg;

  // Last level of the net.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      net_reg <= 1'b0;
    end else begin
      net_reg <= net_next;
    end
  end
endmodule : pmr_gclk_net
`default_nettype wire

/* src/pmr_macrocell.sv */
// One macrocell: sum logic, programmable flip-flop and output select.
`timescale 1ns/100ps
`default_nettype none
module pmr_macrocell (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [pmr_pkg::PMR_NUM_PT-1:0] pt,
  input wire logic [pmr_pkg::PMR_MC_W-1:0] cfg,
  input wire logic pexp_in,
  input wire logic [1:0] gclk_rise,
  input wire logic gclr_act,
  input wire logic pin_d,
  input wire logic load_init,
  output logic pexp_out,
  output logic mc_val,
  output logic q_reg
);
  import pmr_pkg::*;
  logic [PMR_NUM_PT-1:0] sum_sel, sec;
  logic sum_or, sum, pre, clr, edge_hit, ck_prev_reg, d_in, q_next, quiet;
  pmr_ff_type ff;
  pmr_ckmode_type ckm;

  assign sum_sel = cfg[PMR_MC_SUM +: PMR_NUM_PT];
  assign sec = pt & ~sum_sel;
  assign sum_or = (|(pt & sum_sel)) | pexp_in;
  assign sum = sum_or ^ cfg[PMR_MC_XINV];
  assign pexp_out = cfg[PMR_MC_LEND] & sum_or;
  assign pre = sec[PMR_PT_PRE];
  assign clr = sec[PMR_PT_CLR] | (cfg[PMR_MC_GCLR] & gclr_act);
  assign ff = pmr_ff_type'(cfg[PMR_MC_FF +: 2]);
  assign ckm = pmr_ckmode_type'(cfg[PMR_MC_CKM +: 2]);
  assign quiet = !pre && !clr && !load_init;

  always_comb begin
    unique case (ckm)
      PMR_CK_GLOBAL: edge_hit = gclk_rise[cfg[PMR_MC_NET]];
      PMR_CK_GLOBAL_EN: edge_hit = gclk_rise[cfg[PMR_MC_NET]] & sec[PMR_PT_CLK];
      PMR_CK_ARRAY: edge_hit = sec[PMR_PT_CLK] & ~ck_prev_reg;
      default: edge_hit = 1'b0;
    endcase
  end

  always_comb begin
    d_in = cfg[PMR_MC_PIN] ? pin_d : sum;
    unique case (ff)
      PMR_FF_D: q_next = d_in;
      PMR_FF_T: q_next = q_reg ^ d_in;
      PMR_FF_JK: q_next = (d_in & ~q_reg) | (~sec[PMR_PT_K] & q_reg);
      PMR_FF_SR: q_next = d_in | (~sec[PMR_PT_K] & q_reg);
    endcase
  end

  // Array clock history, used to find its rising edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ck_prev_reg <= 1'b0;
    end else begin
      ck_prev_reg <= sec[PMR_PT_CLK];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_reg <= 1'b0;
    end else if (clr) begin
      q_reg <= 1'b0;
    end else if (pre) begin
      q_reg <= 1'b1;
    end else if (load_init) begin
      q_reg <= cfg[PMR_MC_PWRUP];
    end else if (edge_hit) begin
      q_reg <= q_next;
    end
  end

  assign mc_val = cfg[PMR_MC_BYP] ? sum : (~clr & (pre | q_reg));

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_clr_wins;
    pre && clr && !cfg[PMR_MC_BYP] |-> !mc_val ##1 !q_reg;
  endproperty
  a_clr_wins: assert property (p_clr_wins)
    else $error("preset won over clear");
  property p_gclr;
    cfg[PMR_MC_GCLR] && gclr_act |=> !q_reg;
  endproperty
  a_gclr: assert property (p_gclr)
    else $error("global clear did not clear");
  property p_ce_hold;
    ckm == PMR_CK_GLOBAL_EN && !sec[PMR_PT_CLK] && quiet |=> q_reg == $past(q_reg);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("capture without clock enable");
  property p_arr_hold;
    ckm == PMR_CK_ARRAY && !sec[PMR_PT_CLK] && quiet |=> $stable(q_reg);
  endproperty
  a_arr_hold: assert property (p_arr_hold)
    else $error("array mode captured on global clock");
  property p_toggle;
    ff == PMR_FF_T && edge_hit && d_in && quiet |=> q_reg != $past(q_reg);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle flip-flop failed to toggle");
  property p_pwrup_val;
    load_init && !pre && !clr |=> q_reg == $past(cfg[PMR_MC_PWRUP]);
  endproperty
  a_pwrup_val: assert property (p_pwrup_val)
    else $error("power-up state not loaded");
endmodule : pmr_macrocell
`default_nettype wire

/* src/pmr_lab.sv */
// Logic array block: APB configuration, product-term array and macrocells.
//
// How it works
// - A logic array block holds exactly sixteen macrocells.
// - Each block takes 36 general inputs from the global routing array.
// - Each macrocell has five terms, each to the sum or register control.
// - Terms can drive the register preset, clock and clock enable.
// - A macrocell is registered or combinational; combinational bypasses the register.
// - Each register works as a D, T, JK or SR flip-flop.
// - Clock modes: global clock, enabled global clock, or array term clock.
// - In enabled mode, capture only on global edges with enable high.
// - Two global clock nets, each true or inverted of either pin.
// - Term-driven preset and clear are asynchronous and active high; here the register takes them at the next clk edge, only mc_val follows at once.
// - Each register may be cleared by the low global clear pin.
// - At power-up each register takes its own configured level.
// - Each I/O pin has a direct path to its register data input.
// - The direct path delay chooses zero hold or fastest setup.
// - Four dedicated inputs serve as general inputs or global controls; here they only drive the global clocks, clear and output enables.
// - With expanders one macrocell sums up to 40 product terms.
// - Shareable expanders are inverted terms; parallel ones come from neighbours.
// - In test-port mode four I/O pins are lost to user logic.
// - Each block pools sixteen shareable expanders, one per macrocell.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pmr_lab #(
  parameter int unsigned NUM_MC = pmr_pkg::PMR_NUM_MC,
  parameter int unsigned NUM_IN = pmr_pkg::PMR_NUM_IN
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmr_pkg::PMR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] route_in,
  input wire logic [NUM_MC-1:0] io_pin_in,
  input wire logic global_clock_pin_a,
  input wire logic global_clock_pin_b,
  input wire logic global_clear_pin_low,
  input wire logic oe_pin_a,
  output logic [NUM_MC-1:0] mc_out,
  output logic [1:0] global_oe,
  output logic test_port_active
);
  import pmr_pkg::*;

  localparam int DEPTH = NUM_MC * PMR_PT_PER_MC * PMR_WORDS_PER_PT;
  localparam logic [63:0] ROUTE_MASK = 64'((65'h1 << NUM_IN) - 65'h1);

  //////////////////////////////////////////////////////////////////////////////
  // Parameter check.

  // The address map and the two expander chains fit at most two chains of eight.
  if (NUM_MC % PMR_CHAIN != 0 || NUM_MC > PMR_NUM_MC || NUM_IN + NUM_MC > 64) begin : g_bad
    $error("pmr_lab: unsupported NUM_MC or NUM_IN");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic test_reg;
  logic [3:0] gclk_cfg_reg;
  logic [3:0] ded_cfg_reg;
  logic [PMR_MC_W-1:0] mc_cfg_reg [NUM_MC];
  logic [31:0] term_mem [DEPTH];
  logic [NUM_MC-1:0] pin_dly_reg;
  pmr_state_type state_reg, state_next;

  logic setup, wr_acc, hit, mc_hit, t_hit, reload, load_init, gclr_act;
  logic [31:0] rd_val;
  logic [PMR_TIW-1:0] t_idx;
  logic [3:0] m_idx;
  logic ga, gb;
  logic [1:0] net, rise;
  logic [NUM_MC-1:0] pt_shr, shr, pexp_in, pexp_out, mc_val, mc_q, mc_pin, pin_eff;
  logic [NUM_MC-1:0][PMR_NUM_PT-1:0] pt_loc;
  logic [63:0] x_all, x_route;

  // Word address of the first mask word of one term.
  function automatic int wbase(input int m, input int t);
    return (m * PMR_PT_PER_MC + t) * PMR_WORDS_PER_PT;
  endfunction : wbase

  // A term with no literal reads low, so an unprogrammed term never fires.
  function automatic logic pt_eval(input logic [63:0] tm, input logic [63:0] cm,
                                   input logic [63:0] x);
    logic [63:0] ok;
    ok = (~tm | x) & (~cm | ~x);
    return (|(tm | cm)) && (&ok);
  endfunction : pt_eval

  //////////////////////////////////////////////////////////////////////////////
  // APB slave.

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;

  // Address decode and read mux, evaluated in the setup cycle.
  always_comb begin
    rd_val = 32'h0;
    hit = 1'b1;
    mc_hit = 1'b0;
    t_hit = 1'b0;
    t_idx = paddr[PMR_TIW+1:2];
    m_idx = paddr[5:2];
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr[11] == PMR_OFF_TERM[11]) begin
      t_hit = int'(t_idx) < DEPTH;
      hit = t_hit;
      if (t_hit) begin
        rd_val = term_mem[t_idx];
      end
    end else if (paddr[11:6] == PMR_OFF_MC[11:6]) begin
      mc_hit = int'(m_idx) < NUM_MC;
      hit = mc_hit;
      if (mc_hit) begin
        rd_val[PMR_MC_W-1:0] = mc_cfg_reg[m_idx];
      end
    end else begin
      case (paddr)
        PMR_OFF_CTRL: rd_val[PMR_CTRL_TEST] = test_reg;
        PMR_OFF_GCLK: rd_val[3:0] = gclk_cfg_reg;
        PMR_OFF_DED: rd_val[3:0] = ded_cfg_reg;
        PMR_OFF_STAT: begin
          rd_val[NUM_MC-1:0] = mc_out;
          rd_val[PMR_STAT_Q +: NUM_MC] = mc_q;
          rd_val[PMR_STAT_INIT] = load_init;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // One wait-free access cycle: pready rises the cycle after setup.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // Configuration registers; unmapped writes are dropped.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      test_reg <= 1'b0;
      gclk_cfg_reg <= PMR_GCLK_RST;
      ded_cfg_reg <= PMR_DED_RST;
      for (int m = 0; m < NUM_MC; m++) begin
        mc_cfg_reg[m] <= PMR_MC_RST;
      end
    end else if (wr_acc) begin
      if (paddr == PMR_OFF_CTRL) begin
        test_reg <= pwdata[PMR_CTRL_TEST];
      end
      if (paddr == PMR_OFF_GCLK) begin
        gclk_cfg_reg <= pwdata[3:0];
      end
      if (paddr == PMR_OFF_DED) begin
        ded_cfg_reg <= pwdata[3:0];
      end
      if (mc_hit) begin
        mc_cfg_reg[m_idx] <= pwdata[PMR_MC_W-1:0];
      end
    end
  end

  // Term masks: true literals in words 0-1, complement literals in words 2-3.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        term_mem[i] <= 32'h0;
      end
    end else if (wr_acc && t_hit) begin
      term_mem[t_idx] <= pwdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-up load sequence.

  assign reload = wr_acc && paddr == PMR_OFF_CTRL && pwdata[PMR_CTRL_RELOAD];
  assign load_init = state_reg == PMR_ST_INIT;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PMR_ST_INIT: state_next = PMR_ST_RUN;
      PMR_ST_RUN: begin
        if (reload) begin
          state_next = PMR_ST_INIT;
        end
      end
    endcase
  end

  // One cycle in the load state after every reset release or reload.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= PMR_ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dedicated inputs and global nets.

  assign ga = ded_cfg_reg[PMR_DED_CLKA] & global_clock_pin_a;
  assign gb = ~ded_cfg_reg[PMR_DED_PINB_OE] & global_clock_pin_b;
  assign gclr_act = ded_cfg_reg[PMR_DED_CLR] & ~global_clear_pin_low;

  pmr_gclk_net u_net0 (
    .clk(clk),
    .rstn(rstn),
    .pin_a(ga),
    .pin_b(gb),
    .src(gclk_cfg_reg[PMR_GCLK_SRC0]),
    .inv(gclk_cfg_reg[PMR_GCLK_INV0]),
    .net_reg(net[0]),
    .rise(rise[0])
  );
  pmr_gclk_net u_net1 (
    .clk(clk),
    .rstn(rstn),
    .pin_a(ga),
    .pin_b(gb),
    .src(gclk_cfg_reg[PMR_GCLK_SRC1]),
    .inv(gclk_cfg_reg[PMR_GCLK_INV1]),
    .net_reg(net[1]),
    .rise(rise[1])
  );

  //////////////////////////////////////////////////////////////////////////////
  // Product-term array.

  assign x_route = 64'(route_in);
  assign x_all = 64'({shr, route_in});

  // Shareable terms see only routed inputs, which keeps the array loop-free.
  always_comb begin
    pt_shr = '0;
    for (int m = 0; m < NUM_MC; m++) begin
      pt_shr[m] = pt_eval({term_mem[wbase(m, PMR_NUM_PT) + 1], term_mem[wbase(m, PMR_NUM_PT)]}
                          & ROUTE_MASK,
                          {term_mem[wbase(m, PMR_NUM_PT) + 3], term_mem[wbase(m, PMR_NUM_PT) + 2]}
                          & ROUTE_MASK, x_route);
    end
  end

  assign shr = ~pt_shr;

  always_comb begin
    pt_loc = '0;
    for (int m = 0; m < NUM_MC; m++) begin
      for (int t = 0; t < PMR_NUM_PT; t++) begin
        pt_loc[m][t] = pt_eval({term_mem[wbase(m, t) + 1], term_mem[wbase(m, t)]},
                               {term_mem[wbase(m, t) + 3], term_mem[wbase(m, t) + 2]}, x_all);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Direct pin path and macrocells.

  always_comb begin
    pin_eff = io_pin_in;
    if (test_reg) begin
      pin_eff[NUM_MC-1 -: PMR_TEST_PINS] = '0;
    end
  end

  // The extra stage trades setup time for a guaranteed zero hold.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_dly_reg <= '0;
    end else begin
      pin_dly_reg <= pin_eff;
    end
  end

  for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
    assign mc_pin[m] = mc_cfg_reg[m][PMR_MC_HOLD] ? pin_dly_reg[m] : pin_eff[m];
    if (m % PMR_CHAIN == 0) begin : g_head
      assign pexp_in[m] = 1'b0;
    end else begin : g_link
      assign pexp_in[m] = pexp_out[m-1];
    end
    pmr_macrocell u_mc (
      .clk(clk),
      .rstn(rstn),
      .pt(pt_loc[m]),
      .cfg(mc_cfg_reg[m]),
      .pexp_in(pexp_in[m]),
      .gclk_rise(rise),
      .gclr_act(gclr_act),
      .pin_d(mc_pin[m]),
      .load_init(load_init),
      .pexp_out(pexp_out[m]),
      .mc_val(mc_val[m]),
      .q_reg(mc_q[m])
    );
  end

  // Registered pin-side outputs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mc_out <= '0;
      global_oe <= 2'h0;
      test_port_active <= 1'b0;
    end else begin
      mc_out <= mc_val;
      global_oe[0] <= ded_cfg_reg[PMR_DED_OEA] & oe_pin_a;
      global_oe[1] <= ded_cfg_reg[PMR_DED_PINB_OE] & global_clock_pin_b;
      test_port_active <= test_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_apb_ready;
    setup && !pwrite |=> pready && prdata == $past(rd_val) && pslverr == !$past(hit);
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("APB answer wrong");

  property p_test_pins;
    test_reg |-> pin_eff[NUM_MC-1 -: PMR_TEST_PINS] == '0 ##1 test_port_active;
  endproperty
  a_test_pins: assert property (p_test_pins)
    else $error("test port pins still reach user logic");

  property p_net0;
    $stable(gclk_cfg_reg) |=> net[0] == (($past(gclk_cfg_reg[PMR_GCLK_SRC0]) ? $past(gb)
                              : $past(ga)) ^ $past(gclk_cfg_reg[PMR_GCLK_INV0]));
  endproperty
  a_net0: assert property (p_net0)
    else $error("global net 0 has wrong source");

  c_reload: cover property (reload ##1 load_init ##1 !load_init);
  c_slverr: cover property (pready && pslverr);
  c_test: cover property (test_port_active && |mc_out);
endmodule : pmr_lab
`default_nettype wire

/* test/pmr_board.sv */
// Board-side model that drives the block's input pins.
`timescale 1ns/100ps
`default_nettype none
module pmr_board (
  input wire logic clk,
  input wire logic [31:0] rnd,
  input wire logic [7:0] rt,
  input wire logic [15:0] io_c,
  input wire logic ca,
  input wire logic clr_c,
  output logic [35:0] route_in,
  output logic [15:0] io_pin_in,
  output logic pin_a,
  output logic pin_b,
  output logic clr_n,
  output logic oe
);
  // Pins start low, except the clear, which idles released.
  initial begin
    route_in = '0;
    io_pin_in = '0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    clr_n = 1'b1;
    oe = 1'b0;
  end
  // dedicated inputs driven
  // Requests reach the pins one cycle late; unused lines carry noise.
  always @(posedge clk) begin
    route_in <= {rnd[27:0], rt};
    io_pin_in <= io_c;
    pin_a <= ca;
    pin_b <= rnd[28];
    clr_n <= clr_c;
    oe <= rnd[29];
  end
endmodule : pmr_board
`default_nettype wire

/* test/pmr_lab_test.sv */
// Self-checking bench of the logic array block with a bit-level model.
`timescale 1ns/100ps
`default_nettype none
module pmr_lab_test;
  import pmr_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, e, tpa;
  logic gca, gcb, gclr_n, oe, ca, clr_c;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] rnd = 32'he120;
  logic [35:0] route_in;
  logic [15:0] io_pin_in, mc_out, exp_out, io_c;
  logic [7:0] rt;
  logic [1:0] goe, exp_oe;
  int n_mismatch, num_checks;

  pmr_lab u_pmr_lab (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .route_in(route_in), .io_pin_in(io_pin_in),
    .global_clock_pin_a(gca), .global_clock_pin_b(gcb), .global_clear_pin_low(gclr_n),
    .oe_pin_a(oe), .mc_out(mc_out), .global_oe(goe), .test_port_active(tpa));
  pmr_board u_pmr_board (.clk(clk), .rnd(rnd), .rt(rt), .io_c(io_c), .ca(ca),
    .clr_c(clr_c), .route_in(route_in), .io_pin_in(io_pin_in), .pin_a(gca),
    .pin_b(gcb), .clr_n(gclr_n), .oe(oe));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [11:0] term_a(input int m, input int t);
    return 12'h800 + 12'(16 * (m * 6 + t));
  endfunction : term_a
  function automatic logic [11:0] mc_a(input int m);
    return PMR_OFF_MC + 12'(4 * m);
  endfunction : mc_a

  // Clock and the noise source that feeds unused pins.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) rnd <= lfsr(rnd);

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    num_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer; the answer is taken at the edge where pready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("wr_err", 32'h0, {31'h0, e});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("rd_data", x, r);
  endtask : rd
  // Compare every macrocell output with the model, on the pins and in status.
  task automatic chk_out();
    repeat (4) @(posedge clk);
    chk("mc_out", {16'h0, exp_out}, {16'h0, mc_out});
    apb(1'b0, PMR_OFF_STAT, 32'h0);
    chk("stat", {16'h0, exp_out}, {16'h0, r[15:0]});
  endtask : chk_out
  // A rising edge on global clock pin a, with room for it to land.
  task automatic pulse();
    ca <= 1'b0;
    repeat (2) @(posedge clk);
    ca <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Watchdog: the sequence needs a few hundred cycles at most.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {rstn, psel, penable, pwrite, ca} = '0;
    clr_c = 1'b1;
    paddr = '0;
    pwdata = '0;
    rt = '0;
    io_c = '0;
    exp_out = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(PMR_OFF_GCLK, 32'h4);
    rd(PMR_OFF_DED, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    chk("bad_err", 32'h1, {31'h0, e});
    chk("bad_data", 32'h0, r);
    // Macrocell 0 combinational on route line 2, then inverted.
    wr(term_a(0, 0), 32'h4);
    wr(mc_a(0), 32'h201);
    for (int i = 0; i < 3; i++) begin
      rt[2] <= i[0];
      exp_out[0] = i[0];
      chk_out();
    end
    wr(mc_a(0), 32'h601);
    exp_out[0] = 1'b1;
    chk_out();
    // Macrocell 1 takes random pin data, later through the zero-hold delay.
    wr(mc_a(1), 32'h2000);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) wr(mc_a(1), 32'h6000);
      io_c[1] <= rnd[3];
      exp_out[1] = rnd[3];
      pulse();
      chk_out();
    end
    io_c[1] <= 1'b1;
    exp_out[1] = 1'b1;
    pulse();
    wr(mc_a(1), 32'h6800);
    clr_c <= 1'b0;
    io_c[1] <= 1'b0;
    exp_out[1] = 1'b0;
    chk_out();
    clr_c <= 1'b1;
    // Macrocell 8 on an array clock from route line 3 ignores pin a.
    wr(mc_a(8), 32'h2100);
    wr(term_a(8, 2), 32'h8);
    io_c[8] <= 1'b1;
    pulse();
    chk_out();
    rt[3] <= 1'b1;
    exp_out[8] = 1'b1;
    chk_out();
    // Macrocell 3 with clock enable from route line 1.
    wr(mc_a(3), 32'h2080);
    wr(term_a(3, 2), 32'h2);
    io_c[3] <= 1'b1;
    pulse();
    chk_out();
    rt[1] <= 1'b1;
    pulse();
    exp_out[3] = 1'b1;
    chk_out();
    // T, JK and SR flip-flops fed by route line 0.
    rt[0] <= 1'b1;
    wr(term_a(2, 0), 32'h1);
    wr(term_a(6, 0), 32'h1);
    wr(term_a(7, 0), 32'h1);
    wr(mc_a(2), 32'h21);
    wr(mc_a(6), 32'h41);
    wr(mc_a(7), 32'h61);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(term_a(6, 4), 32'h1);
      if (i == 2) wr(term_a(7, 4), 32'h1);
      pulse();
      exp_out[2] = ~exp_out[2];
      exp_out[6] = (i == 2) ? 1'b0 : 1'b1;
      exp_out[7] = 1'b1;
      chk_out();
    end
    // Macrocell 4: preset and clear together, then preset alone.
    wr(mc_a(4), 32'h180);
    wr(term_a(4, 1), 32'h1);
    wr(term_a(4, 3), 32'h1);
    chk_out();
    wr(term_a(4, 3), 32'h0);
    exp_out[4] = 1'b1;
    chk_out();
    // Reload puts every register at its power-up level; preset still wins.
    wr(mc_a(5), 32'h1180);
    wr(PMR_OFF_CTRL, 32'h1);
    exp_out = (exp_out & 16'h0011) | 16'h0020;
    chk_out();
    // Net 0 inverted: the fall of pin a now clocks the registers.
    wr(PMR_OFF_GCLK, 32'h6);
    pulse();
    exp_out = exp_out | 16'h00cc;
    chk_out();
    // Pin b and the enable pin become output enables, one cycle late.
    wr(PMR_OFF_DED, 32'hf);
    repeat (4) begin
      @(posedge clk);
      exp_oe = {gcb, oe};
      @(posedge clk);
      chk("global_oe", {30'h0, exp_oe}, {30'h0, goe});
    end
    wr(PMR_OFF_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk("test_port", 32'h1, {31'h0, tpa});
    wrap_up();
  end
endmodule : pmr_lab_test
`default_nettype wire
